// >>> rtl/sbr_pkg.sv
/*
 * Package for the serial bit-rate generator: register offsets, field layout,
 * reset values and bus encodings.
 * Assumes an AHB-Lite bus with 32-bit data and a single slave.
 */
package sbr_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	// printed offset 0x2 is not a multiple of four: kept as an index
	localparam logic [7:0]  SBR_RATE_CFG_IDX    = 8'h02;
	localparam logic [7:0]  SBR_CTRL_IDX        = 8'h00;
	localparam logic [7:0]  SBR_STATUS_IDX      = 8'h01;

	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int          SBR_PRE_LSB         = 4;
	localparam int          SBR_EXP_LSB         = 0;
	localparam int          SBR_FIELD_W         = 3;
	localparam logic [7:0]  SBR_RATE_WMASK      = 8'h77;
	localparam int          SBR_CTRL_MASTER_BIT = 0;
	localparam int          SBR_CTRL_ENABLE_BIT = 1;
	localparam int          SBR_CNT_W           = 10;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  SBR_RATE_RESET      = 8'h00;
	localparam logic [1:0]  SBR_CTRL_RESET      = 2'h0;

	// ------------------------------------------------------------
	// bus encodings
	// ------------------------------------------------------------
	localparam logic [1:0]  SBR_HTRANS_NONSEQ   = 2'h2;
	localparam logic [1:0]  SBR_HTRANS_SEQ      = 2'h3;

	typedef enum logic [1:0] {
		SBR_IDLE = 2'b01,
		SBR_RUN  = 2'b10
	} sbr_state_e;

endpackage

// >>> rtl/sbr_rate_gen.sv
/*
 * Serial bit-rate generator: AHB-Lite register slave, rate divisor and
 * symmetric serial clock output, plus abort request to the shift engine.
 * Assumes one clock (hclk) shared with the bus and the shift engine.
 * Assumes xfer_busy comes from logic on hclk, so it is read without a synchroniser.
 * Assumes single word transfers; hsize is not decoded and the slave never waits.
 * The shift engine is expected to drop its transfer on the abort_req pulse.
 */
`timescale 1ns/1ps
// Behaviour
// R01: rate register holds prescale select bits 6..4 and exponent select bits 2..0.
// R02: divisor equals (prescale + 1) times two to the (exponent + 1).
// R03: serial bit rate equals bus clock divided by the divisor.
// R04: in master mode a changing rate write aborts transfer and forces idle.
// R05: rate register readable and writable anytime; reserved bits ignore writes.
// R06: zero fields give divisor 2; prescale zero, exponent seven gives 256.
// R07: serial clock toggles every divisor/2 cycles, period exactly divisor cycles.
module sbr_rate_gen
	import sbr_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        xfer_busy,
	output logic             bit_clk,
	output logic             bit_tick,
	output logic             abort_req
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// half period in bus cycles: (pre+1) * 2^exp; divisor is twice that
	function automatic logic [SBR_CNT_W-1:0] half_div(input logic [7:0] cfg);
		logic [SBR_CNT_W-1:0] pre1;
		pre1 = SBR_CNT_W'(cfg[SBR_PRE_LSB +: SBR_FIELD_W]) + SBR_CNT_W'(1);
		half_div = SBR_CNT_W'(pre1 << cfg[SBR_EXP_LSB +: SBR_FIELD_W]);
	endfunction

	function automatic logic [7:0] word_idx(input logic [31:0] a);
		word_idx = a[9:2];
	endfunction

	// read multiplexer: unmapped words read as zero
	function automatic logic [31:0] read_word(
		input logic [7:0] idx,
		input logic [7:0] rate,
		input logic [1:0] ctrl,
		input logic [2:0] status
	);
		case (idx)
			SBR_RATE_CFG_IDX: read_word = {24'h00_0000, rate};
			SBR_CTRL_IDX:     read_word = {30'h0000_0000, ctrl};
			SBR_STATUS_IDX:   read_word = {29'h0000_0000, status};
			default:          read_word = 32'h0000_0000;
		endcase
	endfunction

	// ------------------------------------------------------------
	// address phase capture
	// ------------------------------------------------------------
	logic                 wr_pend_q;
	logic [7:0]           idx_q;
	logic [7:0]           rate_q;
	logic [1:0]           ctrl_q;
	logic [SBR_CNT_W-1:0] cnt_q;
	logic                 clk_q;
	sbr_state_e           state_q;
	logic                 take;
	logic [7:0]           rate_d;
	logic                 rate_chg;
	logic                 rate_wr;
	logic                 pre_chg;
	logic                 exp_chg;
	logic                 master_mode;
	logic                 run_en;
	logic                 abort_now;
	logic [2:0]           status_bits;
	logic [SBR_CNT_W-1:0] div_last;
	logic                 div_wrap;
	logic                 div_restart;

	assign take = hsel && hready && (htrans == SBR_HTRANS_NONSEQ || htrans == SBR_HTRANS_SEQ);

	// write pending for the data phase; reads are answered from the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= take && hwrite;
		end
	end

	// word index held for the data phase of a write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_q <= 8'h00;
		end else if (take) begin
			idx_q <= word_idx(haddr);
		end
	end

	// zero-wait slave: every register answers in one cycle, so no wait state is ever needed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	// nothing is refused, so the response is always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// R05 reserved bits masked
	assign rate_d   = hwdata[7:0] & SBR_RATE_WMASK;
	assign rate_wr  = wr_pend_q && (idx_q == SBR_RATE_CFG_IDX);
	// R04 either field differing counts; rewriting the same value is no change
	assign pre_chg  = rate_d[SBR_PRE_LSB +: SBR_FIELD_W] != rate_q[SBR_PRE_LSB +: SBR_FIELD_W];
	assign exp_chg  = rate_d[SBR_EXP_LSB +: SBR_FIELD_W] != rate_q[SBR_EXP_LSB +: SBR_FIELD_W];
	assign rate_chg = rate_wr && (pre_chg || exp_chg);

	// R01 rate fields stored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rate_q <= SBR_RATE_RESET;
		end else if (wr_pend_q && idx_q == SBR_RATE_CFG_IDX) begin
			rate_q <= rate_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= SBR_CTRL_RESET;
		end else if (wr_pend_q && idx_q == SBR_CTRL_IDX) begin
			ctrl_q <= hwdata[1:0];
		end
	end

	// status: serial clock level, running, abort pulse
	assign status_bits = {clk_q, state_q == SBR_RUN, abort_req};

	// R05 readable any time; unmapped reads zero
	// a read just after a write to the same word sees the old value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata <= read_word(word_idx(haddr), rate_q, ctrl_q, status_bits);
		end
	end

	// ------------------------------------------------------------
	// transfer state and abort
	// ------------------------------------------------------------
	assign master_mode = ctrl_q[SBR_CTRL_MASTER_BIT];
	assign run_en      = ctrl_q[SBR_CTRL_ENABLE_BIT];
	// R04 only a master aborts; a slave takes its clock from the far side
	assign abort_now   = rate_chg && master_mode;

	// R04 one-cycle abort pulse to the shift engine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			abort_req <= 1'b0;
		end else begin
			abort_req <= abort_now;
		end
	end

	// R04 master-mode rate change forces idle
	// a start that meets a rate change waits a cycle so it runs on the new rate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= SBR_IDLE;
		end else begin
			case (state_q)
				SBR_IDLE: begin
					if (xfer_busy && run_en && !rate_chg) begin
						state_q <= SBR_RUN;
					end
				end
				SBR_RUN: begin
					if (abort_now || !xfer_busy || !run_en) begin
						state_q <= SBR_IDLE;
					end
				end
				default: begin
					state_q <= SBR_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// divider
	// ------------------------------------------------------------
	// R02 R06 last count of a half period
	// prescale 7 with exponent 7 gives 1024, which wraps to zero in the counter;
	// minus one still lands on 1023, the right last count, so no extra bit is spent
	assign div_last    = half_div(rate_q) - SBR_CNT_W'(1);
	assign div_wrap    = (cnt_q == div_last);
	// counter restarts on any rate change so the first period is exact
	assign div_restart = (state_q != SBR_RUN) || rate_chg;

	// R07 half-period counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
		end else if (div_restart || div_wrap) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + SBR_CNT_W'(1);
		end
	end

	// R07 internal clock level, toggled each half period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_q <= 1'b0;
		end else if (div_restart) begin
			clk_q <= 1'b0;
		end else if (div_wrap) begin
			clk_q <= !clk_q;
		end
	end

	// R03 serial clock pin: a copy of the level so the pin comes straight from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_clk <= 1'b0;
		end else if (div_restart) begin
			bit_clk <= 1'b0;
		end else if (div_wrap) begin
			bit_clk <= !clk_q;
		end
	end

	// R07 end-of-bit pulse on each falling edge of the serial clock at a half-period end; a restart drops the clock without one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_tick <= 1'b0;
		end else if (div_restart) begin
			bit_tick <= 1'b0;
		end else if (div_wrap) begin
			bit_tick <= clk_q;
		end else begin
			bit_tick <= 1'b0;
		end
	end

endmodule // sbr_rate_gen

// >>> tb/sbr_eng_model.sv
/* stand-in for the shift engine: holds xfer_busy.
   assumes hclk shared with the rate generator. */
`timescale 1ns/1ps
module sbr_eng_model (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic start,
	input  wire logic abort_req,
	output logic      xfer_busy
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) xfer_busy <= 1'b0;
		else if (abort_req) xfer_busy <= 1'b0;
		else if (start) xfer_busy <= 1'b1;
	end
endmodule // sbr_eng_model

// >>> tb/sbr_rate_gen_chk.sv
/* port checker for sbr_rate_gen.
   assumes a bind from the bench top. */
`timescale 1ns/1ps
module sbr_chk
	import sbr_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        xfer_busy,
	input wire logic        bit_clk,
	input wire logic        bit_tick,
	input wire logic        abort_req
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic rd = hsel && hready && htrans[1] && !hwrite;
	a_ready_high: assert property (hreadyout) else $error("wait state");
	a_resp_okay: assert property (!hresp) else $error("bad resp");
	a_rsv_zero: assert property (rd && haddr[9:2] == SBR_RATE_CFG_IDX |=> (hrdata & ~32'h77) == 0) else $error("rsv");
	a_unmapped_zero: assert property (rd && haddr[9:2] > 8'h02 |=> hrdata == 0) else $error("unmapped");
	a_abort_pulse: assert property (abort_req |=> !abort_req) else $error("abort len");
	a_abort_cause: assert property (abort_req |-> $past(hsel && hwrite && htrans[1], 2)) else $error("abort");
	a_tick_pulse: assert property (bit_tick |=> !bit_tick) else $error("tick len");
	a_idle_low: assert property (!xfer_busy [*3] |-> !bit_clk) else $error("idle clk");
	a_rise_busy: assert property ($rose(bit_clk) |-> $past(xfer_busy, 2)) else $error("rise");
	c_abort: cover property (abort_req);
	c_tick: cover property (bit_tick);
	c_rise: cover property ($rose(bit_clk));
endmodule // sbr_chk

// >>> tb/sbr_rate_gen_tb.sv
/* self-checking bench for sbr_rate_gen.
   assumes the package and both tb models compiled first. */
`timescale 1ns/1ps
module sbr_rate_gen_tb;
	import sbr_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, start, xfer_busy, bit_clk, bit_tick, abort_req, hresp, hreadyout;
	logic [31:0] haddr, hwdata, hrdata, r, v;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int num_errors, tests_run, nab, n, p;
	localparam logic [31:0] RATE = {22'h0, SBR_RATE_CFG_IDX, 2'h0};
	assign hready = hreadyout;
	sbr_rate_gen dut(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.xfer_busy(xfer_busy), .bit_clk(bit_clk), .bit_tick(bit_tick), .abort_req(abort_req));
	sbr_eng_model eng(.hclk(hclk), .hresetn(hresetn), .start(start), .abort_req(abort_req), .xfer_busy(xfer_busy));
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) if (abort_req === 1'b1) nab++;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= SBR_HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	function automatic int dv(int pre, int ex);
		return (pre + 1) << (ex + 1);
	endfunction
	task automatic summarize;
		if (num_errors == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#800_000;
		num_errors++;
		summarize();
	end
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, start} = '0;
		hsize = 3'h2;
		void'($urandom(64));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, RATE, 0); chk(r, 0);
		bus(1, RATE, 32'hFF); bus(0, RATE, 0); chk(r, 32'h77);
		bus(0, 32'h0C, 0); chk(r, 0);
		bus(1, 0, 32'h2); start <= 1'b1; @(posedge hclk); start <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			p = (i < 8) ? 0 : $urandom_range(7);
			bus(1, RATE, {25'h0, p[2:0], 1'b0, i[2:0]});
			repeat (2) @(negedge hclk);
			n = 0; while (bit_tick !== 1'b1 && n < 5000) begin @(negedge hclk); n++; end
			n = 0; do begin @(negedge hclk); n++; end while (bit_tick !== 1'b1 && n < 5000);
			chk(n, dv(p, i % 8));
			@(posedge hclk);
		end
		bus(1, 0, 32'h3); bus(0, RATE, 0); v = r ^ 32'h1; nab = 0;
		bus(1, RATE, v); repeat (3) @(posedge hclk); chk(nab, 1); chk(bit_clk, 0);
		start <= 1'b1; @(posedge hclk); start <= 1'b0; nab = 0;
		bus(1, RATE, v); bus(1, 0, 32'h2); bus(1, RATE, v ^ 32'h20); repeat (3) @(posedge hclk);
		chk(nab, 0); chk(xfer_busy, 1);
		bus(0, 0, 0); chk(r, 2); bus(0, 32'h4, 0); chk(r & 32'h2, 2);
		summarize();
	end
endmodule // sbr_rate_gen_tb
bind sbr_rate_gen sbr_chk u_chk(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.xfer_busy(xfer_busy), .bit_clk(bit_clk), .bit_tick(bit_tick), .abort_req(abort_req));
